/* File: rtl/asir_cfg.svh */
// Offsets, field positions and reset values of the alarm status and identity register bank
`ifndef ASIR_CFG_SVH
`define ASIR_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets (7-bit serial address, even byte of each word)
// ----------------------------------------------------------------------------
`define ASIR_OFS_ALARM_STATUS_AXIS_Y 7'h42
`define ASIR_OFS_ALARM_STATUS_AXIS_Z 7'h44
`define ASIR_OFS_ALARM_PEAK_AXIS_X 7'h46
`define ASIR_OFS_ALARM_PEAK_AXIS_Y 7'h48
`define ASIR_OFS_ALARM_PEAK_AXIS_Z 7'h4A
`define ASIR_OFS_CAPTURE_TIME_LOW 7'h4C
`define ASIR_OFS_CAPTURE_TIME_HIGH 7'h4E
`define ASIR_OFS_BUILD_DAY_FW_VERSION 7'h52
`define ASIR_OFS_BUILD_YEAR_MONTH 7'h54
`define ASIR_OFS_PRODUCT_NUMBER 7'h56
`define ASIR_OFS_UNIT_LOT_SERIAL 7'h58
`define ASIR_OFS_OWNER_TAG_STORE 7'h5A

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ASIR_STAT_FLAGS_MSB 15
`define ASIR_STAT_FLAGS_LSB 4
`define ASIR_STAT_UNUSED_BIT 3
`define ASIR_STAT_BAND_MSB 2
`define ASIR_STAT_BAND_LSB 0
`define ASIR_DIGIT_HI_MSB 15
`define ASIR_DIGIT_HI_LSB 12
`define ASIR_DIGIT_MH_MSB 11
`define ASIR_DIGIT_MH_LSB 8
`define ASIR_DIGIT_ML_MSB 7
`define ASIR_DIGIT_ML_LSB 4
`define ASIR_DIGIT_LO_MSB 3
`define ASIR_DIGIT_LO_LSB 0

// ----------------------------------------------------------------------------
// Serial frame layout
// ----------------------------------------------------------------------------
`define ASIR_FRAME_LAST_BIT 4'hF
`define ASIR_CMD_WRITE_BIT 15
`define ASIR_CMD_ADDR_MSB 14
`define ASIR_CMD_ADDR_LSB 8
`define ASIR_CMD_DATA_MSB 7
`define ASIR_CMD_DATA_LSB 0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define ASIR_RST_WORD 16'h0000
`define ASIR_RST_BYTE 8'h00
`define ASIR_RST_COUNT 4'h0

`endif

/* File: rtl/asir_pkg.sv */
// Types shared by the alarm status and identity register bank
package asir_pkg;

    typedef logic [15:0] asir_word_t;
    typedef logic [11:0] asir_flags_t;
    typedef logic [2:0] asir_band_t;
    typedef logic [6:0] asir_addr_t;

    typedef enum logic [1:0] {
        ASIR_IDLE = 2'b01,
        ASIR_FRAME = 2'b10
    } asir_spi_state_t;

endpackage

/* File: rtl/asir_nv_word.sv */
// Owner tag word with restore from nonvolatile backing store after reset
`timescale 1ns/1ps
`default_nettype none
`include "asir_cfg.svh"

module asir_nv_word (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire asir_pkg::asir_word_t restore_word_i,
    input wire logic wr_lo_i,
    input wire logic wr_hi_i,
    input wire logic [7:0] wr_byte_i,
    output asir_pkg::asir_word_t word_o,
    output logic save_o,
    output asir_pkg::asir_word_t save_data_o
);
    import asir_pkg::*;

    asir_word_t word_reg;
    asir_word_t word_next;
    logic restored_reg;
    logic save_reg;
    logic save_next;

    // ------------------------------------------------------------------------
    // Next value: restore once after reset, then byte writes
    // ------------------------------------------------------------------------
    assign word_next = !restored_reg ? restore_word_i :
                       {(wr_hi_i ? wr_byte_i : word_reg[15:8]),
                        (wr_lo_i ? wr_byte_i : word_reg[7:0])};
    assign save_next = restored_reg & (wr_lo_i | wr_hi_i);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            word_reg <= `ASIR_RST_WORD;
            restored_reg <= 1'b0;
            save_reg <= 1'b0;
        end else if (ce_i) begin
            word_reg <= word_next;
            restored_reg <= 1'b1;
            save_reg <= save_next;
        end
    end

    assign word_o = word_reg;
    assign save_o = save_reg & ce_i;
    assign save_data_o = word_reg;

endmodule
`default_nettype wire

/* File: rtl/asir_top.sv */
// Alarm status, alarm peak, capture time and identity registers behind a 16-bit serial port
`timescale 1ns/1ps
`default_nettype none
`include "asir_cfg.svh"

// What this block does
// (R1) Each axis alarm status word holds two alarm flags per band for six bands in bits 15:4.
// (R2) Bits 2:0 of each axis alarm status word give the band, 1 to 6, of the worst alarm.
// (R3) The y and z axes each have their own alarm status word with the same layout.
// (R4) Three read-only words give the peak alarm bin magnitude for x, y and z.
// (R5) The latest capture time in seconds reads as a low word and a high word.
// (R6) The day and firmware word holds day tens, day ones, major and minor digits.
// (R7) The year and month word holds year tens, year ones, month tens and month ones.
// (R8) The product number word returns a fixed value.
// (R9) The lot serial word returns the unit's serial number.
// (R10) The owner tag word is read and write, saved to backing store and restored after reset.
// (R11) Bit 3 of each alarm status word reads zero and writes to read-only words are ignored.
module asir_top #(
    parameter logic [15:0] BUILD_DAY_FW_VERSION = 16'h0000,
    parameter logic [15:0] BUILD_YEAR_MONTH = 16'h0000,
    parameter logic [15:0] PRODUCT_NUMBER = 16'h0123, // Arbitrary value
    parameter logic [15:0] UNIT_LOT_SERIAL = 16'h0000
) (
    input wire logic CORE_CLK_I,
    input wire logic ARST_N_I,
    input wire logic CE_I,
    input wire logic SPI_CS_N_I,
    input wire logic SPI_SCLK_I,
    input wire logic SPI_MOSI_I,
    output logic SPI_MISO_O,
    input wire logic ALARM_UPDATE_I,
    input wire asir_pkg::asir_flags_t ALARM_Y_FLAGS_I,
    input wire asir_pkg::asir_band_t ALARM_Y_BAND_I,
    input wire asir_pkg::asir_flags_t ALARM_Z_FLAGS_I,
    input wire asir_pkg::asir_band_t ALARM_Z_BAND_I,
    input wire asir_pkg::asir_word_t PEAK_X_I,
    input wire asir_pkg::asir_word_t PEAK_Y_I,
    input wire asir_pkg::asir_word_t PEAK_Z_I,
    input wire logic CAPTURE_EVENT_I,
    input wire logic [31:0] CAPTURE_TIME_I,
    input wire asir_pkg::asir_word_t NV_RESTORE_I,
    output logic NV_SAVE_O,
    output asir_pkg::asir_word_t NV_SAVE_DATA_O
);
    import asir_pkg::*;

    // ------------------------------------------------------------------------
    // Reset release through two flip-flops
    // ------------------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_n;

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------------------
    // Alarm status and peak words, loaded by the evaluation strobe
    // ------------------------------------------------------------------------
    asir_flags_t flags_y_reg;
    asir_flags_t flags_z_reg;
    asir_band_t band_y_reg;
    asir_band_t band_z_reg;
    asir_word_t peak_x_reg;
    asir_word_t peak_y_reg;
    asir_word_t peak_z_reg;
    logic [31:0] cap_time_reg;

    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            flags_y_reg <= '0;
            flags_z_reg <= '0;
            band_y_reg <= '0;
            band_z_reg <= '0;
            peak_x_reg <= `ASIR_RST_WORD;
            peak_y_reg <= `ASIR_RST_WORD;
            peak_z_reg <= `ASIR_RST_WORD;
        end else if (CE_I && ALARM_UPDATE_I) begin
            flags_y_reg <= ALARM_Y_FLAGS_I; // [R1] [R3]
            flags_z_reg <= ALARM_Z_FLAGS_I; // [R1] [R3]
            band_y_reg <= ALARM_Y_BAND_I; // [R2]
            band_z_reg <= ALARM_Z_BAND_I; // [R2]
            peak_x_reg <= PEAK_X_I; // [R4]
            peak_y_reg <= PEAK_Y_I; // [R4]
            peak_z_reg <= PEAK_Z_I; // [R4]
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            cap_time_reg <= '0;
        end else if (CE_I && CAPTURE_EVENT_I) begin
            cap_time_reg <= CAPTURE_TIME_I; // [R5]
        end
    end

    // ------------------------------------------------------------------------
    // Assembled register words
    // ------------------------------------------------------------------------
    asir_word_t stat_y_word;
    asir_word_t stat_z_word;
    asir_word_t day_word;
    asir_word_t year_word;
    asir_word_t owner_word;

    assign stat_y_word = {flags_y_reg, 1'b0, band_y_reg}; // [R1] [R2] [R11]
    assign stat_z_word = {flags_z_reg, 1'b0, band_z_reg}; // [R1] [R2] [R3] [R11]
    assign day_word = {BUILD_DAY_FW_VERSION[`ASIR_DIGIT_HI_MSB:`ASIR_DIGIT_HI_LSB],
                       BUILD_DAY_FW_VERSION[`ASIR_DIGIT_MH_MSB:`ASIR_DIGIT_MH_LSB],
                       BUILD_DAY_FW_VERSION[`ASIR_DIGIT_ML_MSB:`ASIR_DIGIT_ML_LSB],
                       BUILD_DAY_FW_VERSION[`ASIR_DIGIT_LO_MSB:`ASIR_DIGIT_LO_LSB]}; // [R6]
    assign year_word = {BUILD_YEAR_MONTH[`ASIR_DIGIT_HI_MSB:`ASIR_DIGIT_HI_LSB],
                        BUILD_YEAR_MONTH[`ASIR_DIGIT_MH_MSB:`ASIR_DIGIT_MH_LSB],
                        BUILD_YEAR_MONTH[`ASIR_DIGIT_ML_MSB:`ASIR_DIGIT_ML_LSB],
                        BUILD_YEAR_MONTH[`ASIR_DIGIT_LO_MSB:`ASIR_DIGIT_LO_LSB]}; // [R7]

    // ------------------------------------------------------------------------
    // Serial port: edge detection on synchronous pin samples
    // ------------------------------------------------------------------------
    asir_spi_state_t state_reg;
    asir_spi_state_t state_next;
    logic sclk_prev_reg;
    logic cs_n_prev_reg;
    logic [3:0] bit_cnt_reg;
    logic [14:0] rx_reg;
    asir_word_t tx_reg;
    asir_word_t resp_reg;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_start;
    logic frame_done;
    asir_word_t frame_word;
    asir_addr_t cmd_addr;
    asir_addr_t word_addr;
    logic cmd_write;
    logic [7:0] cmd_byte;
    logic wr_owner_lo;
    logic wr_owner_hi;
    asir_word_t read_word;

    assign sclk_rise = (state_reg == ASIR_FRAME) & ~SPI_CS_N_I & SPI_SCLK_I & ~sclk_prev_reg;
    assign sclk_fall = (state_reg == ASIR_FRAME) & ~SPI_CS_N_I & ~SPI_SCLK_I & sclk_prev_reg;
    assign cs_start = cs_n_prev_reg & ~SPI_CS_N_I;
    assign frame_done = sclk_rise & (bit_cnt_reg == `ASIR_FRAME_LAST_BIT);
    assign frame_word = {rx_reg, SPI_MOSI_I};

    // ------------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------------
    assign cmd_write = frame_word[`ASIR_CMD_WRITE_BIT];
    assign cmd_addr = frame_word[`ASIR_CMD_ADDR_MSB:`ASIR_CMD_ADDR_LSB];
    assign cmd_byte = frame_word[`ASIR_CMD_DATA_MSB:`ASIR_CMD_DATA_LSB];
    assign word_addr = {cmd_addr[6:1], 1'b0};
    // Only the owner tag accepts writes; all other addresses drop them
    assign wr_owner_lo = CE_I & frame_done & cmd_write &
                         (cmd_addr == `ASIR_OFS_OWNER_TAG_STORE); // [R10] [R11]
    assign wr_owner_hi = CE_I & frame_done & cmd_write &
                         (cmd_addr == (`ASIR_OFS_OWNER_TAG_STORE | 7'h01)); // [R10] [R11]

    // ------------------------------------------------------------------------
    // Read selection; unmapped words read zero
    // ------------------------------------------------------------------------
    always_comb begin
        case (word_addr)
            `ASIR_OFS_ALARM_STATUS_AXIS_Y: read_word = stat_y_word; // [R3]
            `ASIR_OFS_ALARM_STATUS_AXIS_Z: read_word = stat_z_word; // [R3]
            `ASIR_OFS_ALARM_PEAK_AXIS_X: read_word = peak_x_reg; // [R4]
            `ASIR_OFS_ALARM_PEAK_AXIS_Y: read_word = peak_y_reg; // [R4]
            `ASIR_OFS_ALARM_PEAK_AXIS_Z: read_word = peak_z_reg; // [R4]
            `ASIR_OFS_CAPTURE_TIME_LOW: read_word = cap_time_reg[15:0]; // [R5]
            `ASIR_OFS_CAPTURE_TIME_HIGH: read_word = cap_time_reg[31:16]; // [R5]
            `ASIR_OFS_BUILD_DAY_FW_VERSION: read_word = day_word; // [R6]
            `ASIR_OFS_BUILD_YEAR_MONTH: read_word = year_word; // [R7]
            `ASIR_OFS_PRODUCT_NUMBER: read_word = PRODUCT_NUMBER; // [R8]
            `ASIR_OFS_UNIT_LOT_SERIAL: read_word = UNIT_LOT_SERIAL; // [R9]
            `ASIR_OFS_OWNER_TAG_STORE: read_word = owner_word; // [R10]
            default: read_word = `ASIR_RST_WORD;
        endcase
    end

    // ------------------------------------------------------------------------
    // Frame state machine
    // ------------------------------------------------------------------------
    always_comb begin
        case (state_reg)
            ASIR_IDLE: state_next = cs_start ? ASIR_FRAME : ASIR_IDLE;
            ASIR_FRAME: state_next = SPI_CS_N_I ? ASIR_IDLE : ASIR_FRAME;
            default: state_next = ASIR_IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ASIR_IDLE;
            sclk_prev_reg <= 1'b1;
            cs_n_prev_reg <= 1'b1;
        end else if (CE_I) begin
            state_reg <= state_next;
            sclk_prev_reg <= SPI_SCLK_I;
            cs_n_prev_reg <= SPI_CS_N_I;
        end
    end

    // ------------------------------------------------------------------------
    // Receive shift and bit count
    // ------------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_reg <= `ASIR_RST_COUNT;
            rx_reg <= '0;
        end else if (CE_I) begin
            if (cs_start) begin
                bit_cnt_reg <= `ASIR_RST_COUNT;
            end else if (sclk_rise) begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                rx_reg <= frame_word[14:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Response word: a read command is answered in the following frame
    // ------------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            resp_reg <= `ASIR_RST_WORD;
        end else if (CE_I && frame_done) begin
            resp_reg <= cmd_write ? `ASIR_RST_WORD : read_word;
        end
    end

    // Transmit shifts on falling clock once the first bit has been sampled
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            tx_reg <= `ASIR_RST_WORD;
        end else if (CE_I) begin
            if (cs_start) begin
                tx_reg <= resp_reg;
            end else if (sclk_fall && bit_cnt_reg != `ASIR_RST_COUNT) begin
                tx_reg <= {tx_reg[14:0], 1'b0};
            end
        end
    end

    assign SPI_MISO_O = tx_reg[15];

    // ------------------------------------------------------------------------
    // Owner tag with nonvolatile backing
    // ------------------------------------------------------------------------
    asir_nv_word u_owner_tag (
        .clk_i(CORE_CLK_I),
        .rst_n_i(rst_n),
        .ce_i(CE_I),
        .restore_word_i(NV_RESTORE_I), // [R10]
        .wr_lo_i(wr_owner_lo),
        .wr_hi_i(wr_owner_hi),
        .wr_byte_i(cmd_byte),
        .word_o(owner_word),
        .save_o(NV_SAVE_O),
        .save_data_o(NV_SAVE_DATA_O)
    );

endmodule
`default_nettype wire

/* File: sim/asir_top_asserts.sv */
// Concurrent checks on the serial answer line and the owner tag save outputs
`timescale 1ns/1ps
`default_nettype none
module asir_top_asserts (
    input wire logic CORE_CLK_I,
    input wire logic ARST_N_I,
    input wire logic CE_I,
    input wire logic SPI_CS_N_I,
    input wire logic SPI_MISO_O,
    input wire logic NV_SAVE_O,
    input wire asir_pkg::asir_word_t NV_SAVE_DATA_O
);
    import asir_pkg::*;
    // Cycles since chip select was last seen low, saturating
    logic [3:0] idle_cnt_reg;
    logic [3:0] idle_cnt_next;
    assign idle_cnt_next = !SPI_CS_N_I ? 4'h0 :
                           ((idle_cnt_reg == 4'hF) ? 4'hF : idle_cnt_reg + 4'h1);
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            idle_cnt_reg <= 4'hF;
        end else begin
            idle_cnt_reg <= idle_cnt_next;
        end
    end
    // Owner tag reloads from backing store at the first enabled edge once reset is out
    logic [1:0] rel_cnt_reg;
    logic loaded_reg;
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rel_cnt_reg <= 2'h0;
            loaded_reg <= 1'b0;
        end else begin
            if (rel_cnt_reg != 2'h3) begin
                rel_cnt_reg <= rel_cnt_reg + 2'h1;
            end
            if (rel_cnt_reg >= 2'h2 && CE_I) begin
                loaded_reg <= 1'b1;
            end
        end
    end
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!ARST_N_I);
    chk_reset_quiet: assert property (
        $rose(ARST_N_I) |-> !SPI_MISO_O && !NV_SAVE_O && NV_SAVE_DATA_O == 16'h0000)
        else $error("outputs not cleared by reset");
    chk_save_single: assert property (NV_SAVE_O |=> !NV_SAVE_O [*8])
        else $error("save pulse too long or repeated");
    chk_save_data_hold: assert property (
        !NV_SAVE_O && $past(loaded_reg) |-> $stable(NV_SAVE_DATA_O))
        else $error("save data moved without save pulse");
    chk_ce_no_save: assert property (!CE_I |-> !NV_SAVE_O)
        else $error("save pulse while clock enable low");
    chk_ce_freeze: assert property (
        !CE_I |=> $stable(SPI_MISO_O) && $stable(NV_SAVE_DATA_O))
        else $error("state moved while clock enable low");
    chk_miso_idle_hold: assert property (SPI_CS_N_I [*4] |-> $stable(SPI_MISO_O))
        else $error("answer line moved outside a frame");
    chk_save_in_frame: assert property (NV_SAVE_O |-> idle_cnt_reg < 4'h8)
        else $error("save pulse far from any frame");
    chk_restore_no_save: assert property ($rose(ARST_N_I) |-> !NV_SAVE_O [*6])
        else $error("restore after reset raised a save");
endmodule
bind asir_top asir_top_asserts asir_top_asserts_inst (.*);
`default_nettype wire

/* File: sim/asir_host_model.sv */
// Serial host that runs 16-bit mode 3 frames against the register bank
`timescale 1ns/1ps
`default_nettype none
module asir_host_model (
    input wire logic clk_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic mosi_o,
    input wire logic miso_i
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b1;
        mosi_o = 1'b1;
    end
    // One frame: command word out, answer to the previous frame in
    task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
        @(negedge clk_i);
        cs_n_o = 1'b0;
        repeat (3) @(negedge clk_i);
        for (int i = 15; i >= 0; i--) begin
            sclk_o = 1'b0;
            mosi_o = cmd[i];
            repeat (3) @(negedge clk_i);
            sclk_o = 1'b1;
            rsp[i] = miso_i;
            repeat (2) @(negedge clk_i);
        end
        cs_n_o = 1'b1;
        // Released data line must not keep looking valid
        mosi_o = ~mosi_o;
        repeat (2) @(negedge clk_i);
    endtask
endmodule
`default_nettype wire

/* File: sim/asir_tb_top.sv */
// Self-checking bench for the alarm status and identity register bank
`timescale 1ns/1ps
`default_nettype none
module asir_tb_top;
    import asir_pkg::*;
    localparam asir_word_t DAY_V = 16'h2813;
    localparam asir_word_t YM_V = 16'h2406;
    localparam asir_word_t PROD_V = 16'h0456; // Arbitrary value
    localparam asir_word_t SER_V = 16'h00A5;
    logic clk, arst_n, ce, upd, cap, miso, sv;
    wire logic cs_n, sclk, mosi;
    asir_flags_t fy, fz;
    asir_band_t by, bz;
    asir_word_t px, py, pz, nvr, svd, last_save;
    logic [31:0] ctm;
    asir_word_t ex[0:12];
    int err_count, num_checks, save_cnt, seed;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    asir_top #(.BUILD_DAY_FW_VERSION(DAY_V), .BUILD_YEAR_MONTH(YM_V), .PRODUCT_NUMBER(PROD_V),
        .UNIT_LOT_SERIAL(SER_V)) asir_top_inst (.CORE_CLK_I(clk), .ARST_N_I(arst_n), .CE_I(ce),
        .SPI_CS_N_I(cs_n), .SPI_SCLK_I(sclk), .SPI_MOSI_I(mosi), .SPI_MISO_O(miso),
        .ALARM_UPDATE_I(upd), .ALARM_Y_FLAGS_I(fy), .ALARM_Y_BAND_I(by), .ALARM_Z_FLAGS_I(fz),
        .ALARM_Z_BAND_I(bz), .PEAK_X_I(px), .PEAK_Y_I(py), .PEAK_Z_I(pz), .CAPTURE_EVENT_I(cap),
        .CAPTURE_TIME_I(ctm), .NV_RESTORE_I(nvr), .NV_SAVE_O(sv), .NV_SAVE_DATA_O(svd));
    asir_host_model asir_host_model_inst (.clk_i(clk), .cs_n_o(cs_n), .sclk_o(sclk),
        .mosi_o(mosi), .miso_i(miso));
    always @(negedge clk) begin
        if (sv === 1'b1) begin
            save_cnt++;
            last_save = svd;
        end
    end
    function automatic asir_word_t exp_rd(asir_addr_t a);
        if (a < 7'h42 || a > 7'h5B) return 16'h0000;
        return ex[(a - 7'h42) >> 1];
    endfunction
    task automatic chk(input asir_word_t got, input asir_word_t exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input asir_addr_t a);
        asir_word_t x;
        asir_host_model_inst.xfer({1'b0, a, 8'h00}, x);
        asir_host_model_inst.xfer(16'h0000, x);
        chk(x, exp_rd(a));
    endtask
    task automatic wr(input asir_addr_t a, input logic [7:0] b);
        asir_word_t x;
        int c0;
        c0 = save_cnt;
        asir_host_model_inst.xfer({1'b1, a, b}, x);
        asir_host_model_inst.xfer(16'h0000, x);
        chk(x, 16'h0000);
        if (a == 7'h5A) ex[12][7:0] = b;
        if (a == 7'h5B) ex[12][15:8] = b;
        chk(16'(save_cnt - c0), (a[6:1] == 6'h2D) ? 16'h0001 : 16'h0000);
        if (a[6:1] == 6'h2D) chk(last_save, ex[12]);
    endtask
    task automatic do_reset();
        @(negedge clk);
        arst_n = 1'b0;
        repeat (4) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        for (int i = 0; i < 8; i++) ex[i] = 16'h0000;
        ex[8] = DAY_V;
        ex[9] = YM_V;
        ex[10] = PROD_V;
        ex[11] = SER_V;
        ex[12] = nvr;
    endtask
    // Load alarm inputs, then move them again without an update
    task automatic load(input int i);
        fy = (i == 1) ? 12'hFFF : 12'($urandom);
        fz = (i == 2) ? 12'h000 : 12'($urandom);
        by = 3'(i);
        bz = 3'(7 - i);
        px = 16'($urandom);
        py = 16'($urandom);
        pz = 16'($urandom);
        ctm = $urandom;
        upd = 1'b1;
        cap = i[0];
        @(negedge clk);
        upd = 1'b0;
        cap = 1'b0;
        ex[0] = {fy, 1'b0, by};
        ex[1] = {fz, 1'b0, bz};
        ex[2] = px;
        ex[3] = py;
        ex[4] = pz;
        if (i[0]) ex[5] = ctm[15:0];
        if (i[0]) ex[6] = ctm[31:16];
        fy = 12'($urandom);
        pz = 16'($urandom);
        ctm = $urandom;
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #900000;
        err_count++;
        $display("[ERR] %0t run timed out", $time);
        close_out();
    end
    initial begin
        arst_n = 1'b0;
        ce = 1'b1;
        upd = 1'b0;
        cap = 1'b0;
        {fy, fz, by, bz, px, py, pz, ctm} = '0;
        nvr = 16'hC35A;
        seed = $urandom(14);
        do_reset();
        for (int a = 7'h40; a <= 7'h5D; a++) rd_chk(7'(a));
        $display("test reset_values done");
        for (int i = 1; i <= 6; i++) begin
            load(i);
            rd_chk(7'(7'h42 + i % 2));
            rd_chk(7'h44);
            for (int a = 7'h46; a <= 7'h4A; a += 2) rd_chk(7'(a));
            rd_chk(7'h4C);
            rd_chk(7'h4F);
        end
        $display("test alarm_words done");
        wr(7'h5A, 8'($urandom));
        wr(7'h5B, 8'($urandom));
        rd_chk(7'h5B);
        wr(7'h56, 8'hFF);
        wr(7'h42, 8'h08);
        wr(7'h5C, 8'h5A);
        rd_chk(7'h56);
        rd_chk(7'h42);
        $display("test owner_tag done");
        ce = 1'b0;
        upd = 1'b1;
        repeat (6) @(negedge clk);
        upd = 1'b0;
        ce = 1'b1;
        rd_chk(7'h43);
        rd_chk(7'h5A);
        $display("test clock_enable done");
        nvr = ex[12];
        do_reset();
        rd_chk(7'h5A);
        rd_chk(7'h4E);
        $display("test nv_restore done");
        close_out();
    end
endmodule
`default_nettype wire
